//--- intc_pkg.sv
`default_nettype none
package intc_pkg;

    localparam int NUM_EXT = 5;
    localparam int NUM_LVL = 16;
    localparam int LVL_W = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int HW_ERR_W = 8;
    localparam int FILTER_CYCLES = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SHAPE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

    // Reset values
    localparam logic [NUM_LVL-1:0] MASK_RESET = 16'h7FFE;
    localparam logic [DATA_W-1:0] SHAPE_RESET = 32'h0000_0000;

    // Shape register fields
    localparam int SHP_POL_LSB = 0;
    localparam int SHP_EDGE_LSB = 5;
    localparam int SHP_ACK_EN_BIT = 10;
    localparam int SHP_ACK_SEL_LSB = 11;
    localparam int SHP_ACK_SEL_W = 3;
    localparam int SHP_USED_W = 14;

    // Status register fields
    localparam int STS_LVL_LSB = 0;
    localparam int STS_HALT_BIT = 4;

    // Interrupt levels of each source
    localparam logic [LVL_W-1:0] LVL_WDOG = 4'hF;
    localparam logic [LVL_W-1:0] LVL_EXT4 = 4'hE;
    localparam logic [LVL_W-1:0] LVL_RTC = 4'hD;
    localparam logic [LVL_W-1:0] LVL_GPT = 4'hC;
    localparam logic [LVL_W-1:0] LVL_EXT3 = 4'hB;
    localparam logic [LVL_W-1:0] LVL_EXT2 = 4'hA;
    localparam logic [LVL_W-1:0] LVL_DMA_TMO = 4'h9;
    localparam logic [LVL_W-1:0] LVL_DMA_ERR = 4'h8;
    localparam logic [LVL_W-1:0] LVL_SER_ERR = 4'h7;
    localparam logic [LVL_W-1:0] LVL_MEM_CORR = 4'h6;
    localparam logic [LVL_W-1:0] LVL_SER_B = 4'h5;
    localparam logic [LVL_W-1:0] LVL_SER_A = 4'h4;
    localparam logic [LVL_W-1:0] LVL_EXT1 = 4'h3;
    localparam logic [LVL_W-1:0] LVL_EXT0 = 4'h2;
    localparam logic [LVL_W-1:0] LVL_HW_ERR = 4'h1;
    localparam logic [LVL_W-1:0] LVL_NONE = 4'h0;

    // Trap type is this base in the upper nibble and the level in the lower nibble
    localparam logic [LVL_W-1:0] TT_BASE_HI = 4'h1;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // Internal events, one-cycle pulses from on-chip logic
    typedef struct packed {
        logic wdog_timeout;
        logic rtc_tick;
        logic gpt_expiry;
        logic dma_timeout;
        logic dma_access_err;
        logic ser_err;
        logic mem_corrected;
        logic ser_b_ready;
        logic ser_a_ready;
    } evt_t;

endpackage
`default_nettype wire

//--- ext_irq_filter.sv
`timescale 1ns/1ns
`default_nettype none
module ext_irq_filter
    import intc_pkg::*;
#(
    parameter int MIN_ACTIVE = FILTER_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and its shape
    input wire logic pin,
    input wire logic active_high,
    input wire logic edge_mode,
    // Qualified request
    output logic hit
);
    logic sync_a;
    logic sync_b;
    logic [MIN_ACTIVE-1:0] hist;
    logic qual_d;
    logic active;
    logic qual;

    assign active = active_high ? sync_b : ~sync_b;
    // Active seen on every one of the last MIN_ACTIVE cycles
    assign qual = &hist;
    // Edge mode fires once on entry to the active state
    assign hit = edge_mode ? (qual & ~qual_d) : qual;

    // Synchronisers rest high, the idle level of an active-low pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    // History starts empty so no level request appears after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist <= '0;
            qual_d <= 1'b1;
        end else begin
            hist <= {hist[MIN_ACTIVE-2:0], active};
            qual_d <= qual;
        end
    end
endmodule
`default_nettype wire

//--- interrupt_trap_controller.sv
// Operation
// - Fifteen asynchronous events, fixed levels 1 to 15, trap type 0x10 plus level
// - Levels 15..9: watchdog, ext4, real-time tick, timer, ext3, ext2, DMA timeout
// - Levels 8..1: DMA error, serial error, ECC, serial B, A, ext1, ext0, hw
// - Every level has a mask bit except level 15, which is never masked
// - Pending bits readable; writing one to clear register clears pending bit
// - Core acknowledge clears the pending bit chosen by the sampled trap type
// - Request level outputs carry highest-priority pending interrupt
// - Higher interrupt arriving before acknowledge replaces the lower request
// - Shape register selects active low or active high per external input
// - Shape register selects edge or level sensitivity per external input
// - One selected external input pulses ext_ack_pulse when acknowledged
// - External inputs count only after two consecutive active clock cycles
// - Edge mode sets pending only on transition into the active polarity
// - Level mode pending follows input: set while asserted, cleared after
// - Masked hardware errors interrupt; unmasked ones request halt or reset
// - Five external interrupt inputs, each at its own distinct priority
// - Per-channel serial interrupt plus one shared serial error interrupt
// - Timer, watchdog, DMA and corrected-memory events set own pending bits
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module interrupt_trap_controller
    import intc_pkg::*;
#(
    parameter int HW_ERR_BITS = HW_ERR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    // External interrupt pins
    input wire logic [NUM_EXT-1:0] ext_irq,
    // On-chip event sources
    input wire evt_t evt,
    input wire logic [HW_ERR_BITS-1:0] hw_err_flags,
    input wire logic [HW_ERR_BITS-1:0] hw_err_masked,
    output logic hw_err_halt_req,
    // Processor core side
    output logic [LVL_W-1:0] request_level_outputs,
    input wire logic irq_ack,
    input wire logic [7:0] ack_trap_type,
    output logic ext_ack_pulse
);
    // Level of each external input, indexed by input number
    function automatic logic [LVL_W-1:0] ext_level(input int idx);
        case (idx)
            0: ext_level = LVL_EXT0;
            1: ext_level = LVL_EXT1;
            2: ext_level = LVL_EXT2;
            3: ext_level = LVL_EXT3;
            4: ext_level = LVL_EXT4;
            default: ext_level = LVL_NONE;
        endcase
    endfunction

    // Highest set bit of a request vector; bit 0 never counts
    function automatic logic [LVL_W-1:0] top_level(
        input logic [NUM_LVL-1:0] v);
        logic [LVL_W-1:0] r;
        r = LVL_NONE;
        for (int i = 1; i < NUM_LVL; i++) begin
            if (v[i]) begin
                r = LVL_W'(i);
            end
        end
        top_level = r;
    endfunction

    logic rst_meta;
    logic rst_n;
    logic [NUM_LVL-1:0] pending;
    logic [NUM_LVL-1:0] mask;
    logic [DATA_W-1:0] shape;
    logic [NUM_LVL-1:0] next_pending;
    logic [NUM_LVL-1:0] set_vec;
    logic [NUM_LVL-1:0] follow_vec;
    logic [NUM_LVL-1:0] clear_vec;
    logic [NUM_LVL-1:0] ack_vec;
    logic [NUM_LVL-1:0] sw_clear_vec;
    logic [NUM_LVL-1:0] eligible;
    logic [NUM_EXT-1:0] ext_hit;
    logic [NUM_EXT-1:0] ext_pol;
    logic [NUM_EXT-1:0] ext_edge;
    logic [SHP_ACK_SEL_W-1:0] ack_sel;
    logic ack_en;
    logic ack_valid;
    logic [LVL_W-1:0] ack_lvl;
    logic hw_int;
    logic next_halt;
    logic next_ext_ack;
    logic [LVL_W-1:0] next_level;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
    logic [DATA_W-1:0] next_prdata;

    // Reset is released through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // APB decode
    wire setup_ph = apb_req.psel & ~apb_req.penable;
    wire access_ph = apb_req.psel & apb_req.penable;
    wire sel_pending = apb_req.paddr == OFF_PENDING;
    wire sel_mask = apb_req.paddr == OFF_MASK;
    wire sel_clear = apb_req.paddr == OFF_CLEAR;
    wire sel_shape = apb_req.paddr == OFF_SHAPE;
    wire sel_status = apb_req.paddr == OFF_STATUS;
    wire mapped = sel_pending | sel_mask | sel_clear | sel_shape
        | sel_status;
    wire wr_en = access_ph & apb_req.pwrite & mapped;
    wire wr_mask = wr_en & sel_mask;
    wire wr_clear = wr_en & sel_clear;
    wire wr_shape = wr_en & sel_shape;

    // Zero wait states; read data and error are set up during setup
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.prdata = prdata;
    assign apb_rsp.pslverr = pslverr;

    always_comb begin
        next_prdata = '0;
        if (sel_pending) begin
            next_prdata[NUM_LVL-1:0] = pending;
        end else if (sel_mask) begin
            next_prdata[NUM_LVL-1:0] = mask;
        end else if (sel_shape) begin
            next_prdata = shape;
        end else if (sel_status) begin
            next_prdata[STS_LVL_LSB +: LVL_W] = request_level_outputs;
            next_prdata[STS_HALT_BIT] = hw_err_halt_req;
        end else begin
            // Clear register is write-only and reads as zero
            next_prdata = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata <= apb_req.pwrite ? '0 : next_prdata;
            pslverr <= ~mapped;
        end
    end

    // Bit 15 cannot be masked and bit 0 does not exist
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= MASK_RESET;
        end else if (wr_mask) begin
            mask <= {1'b0, apb_req.pwdata[NUM_LVL-2:1], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shape <= SHAPE_RESET;
        end else if (wr_shape) begin
            shape <= {{(DATA_W-SHP_USED_W){1'b0}},
                apb_req.pwdata[SHP_USED_W-1:0]};
        end
    end

    assign ext_pol = shape[SHP_POL_LSB +: NUM_EXT];
    assign ext_edge = shape[SHP_EDGE_LSB +: NUM_EXT];
    assign ack_en = shape[SHP_ACK_EN_BIT];
    assign ack_sel = shape[SHP_ACK_SEL_LSB +: SHP_ACK_SEL_W];

    // One filter per external input
    generate
        for (genvar g = 0; g < NUM_EXT; g++) begin : gen_ext
            ext_irq_filter #(
                .MIN_ACTIVE(FILTER_CYCLES)
            ) u_filter (
                .clk(clk),
                .rst_n(rst_n),
                .pin(ext_irq[g]),
                .active_high(ext_pol[g]),
                .edge_mode(ext_edge[g]),
                .hit(ext_hit[g])
            );
        end
    endgenerate

    // Hardware errors: masked ones interrupt, the rest request a halt
    assign hw_int = |(hw_err_flags & hw_err_masked);
    assign next_halt = |(hw_err_flags & ~hw_err_masked);

    // Source to level map
    always_comb begin
        set_vec = '0;
        follow_vec = '0;
        set_vec[LVL_WDOG] = evt.wdog_timeout;
        set_vec[LVL_RTC] = evt.rtc_tick;
        set_vec[LVL_GPT] = evt.gpt_expiry;
        set_vec[LVL_DMA_TMO] = evt.dma_timeout;
        set_vec[LVL_DMA_ERR] = evt.dma_access_err;
        set_vec[LVL_SER_ERR] = evt.ser_err;
        set_vec[LVL_MEM_CORR] = evt.mem_corrected;
        set_vec[LVL_SER_B] = evt.ser_b_ready;
        set_vec[LVL_SER_A] = evt.ser_a_ready;
        set_vec[LVL_HW_ERR] = hw_int;
        for (int i = 0; i < NUM_EXT; i++) begin
            set_vec[ext_level(i)] = ext_hit[i];
            follow_vec[ext_level(i)] = ~ext_edge[i];
        end
    end

    // Acknowledge decode: trap types 0x11..0x1F name levels 1..15
    assign ack_lvl = ack_trap_type[LVL_W-1:0];
    assign ack_valid = irq_ack && ack_trap_type[7:4] == TT_BASE_HI
        && ack_lvl != LVL_NONE;
    assign ack_vec = ack_valid ? (NUM_LVL'(1) << ack_lvl) : '0;
    assign sw_clear_vec = wr_clear ? apb_req.pwdata[NUM_LVL-1:0] : '0;
    assign clear_vec = ack_vec | sw_clear_vec;

    // A new event in the clear cycle wins; level inputs just follow the pin
    always_comb begin
        next_pending = '0;
        for (int i = 1; i < NUM_LVL; i++) begin
            if (follow_vec[i]) begin
                next_pending[i] = set_vec[i];
            end else begin
                next_pending[i] = set_vec[i]
                    | (pending[i] & ~clear_vec[i]);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // Masked bits stay pending but do not compete
    assign eligible = pending & ~mask;
    // Re-evaluated every cycle, so a higher arrival replaces the request
    assign next_level = top_level(eligible);

    // Pulse only when the chosen external input's level is acknowledged
    always_comb begin
        next_ext_ack = 1'b0;
        if (ack_valid && ack_en && int'(ack_sel) < NUM_EXT) begin
            next_ext_ack = ack_lvl == ext_level(int'(ack_sel));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            request_level_outputs <= LVL_NONE;
        end else begin
            request_level_outputs <= next_level;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_ack_pulse <= 1'b0;
        end else begin
            ext_ack_pulse <= next_ext_ack;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_err_halt_req <= 1'b0;
        end else begin
            hw_err_halt_req <= next_halt;
        end
    end
endmodule
`default_nettype wire

//--- intc_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module intc_checker
    import intc_pkg::*;
#(
    parameter int HW_ERR_BITS = HW_ERR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bus and sources
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire logic [NUM_EXT-1:0] ext_irq,
    input wire evt_t evt,
    input wire logic [HW_ERR_BITS-1:0] hw_err_flags,
    input wire logic [HW_ERR_BITS-1:0] hw_err_masked,
    // Outputs and core side
    input wire logic hw_err_halt_req,
    input wire logic [LVL_W-1:0] request_level_outputs,
    input wire logic irq_ack,
    input wire logic [7:0] ack_trap_type,
    input wire logic ext_ack_pulse
);
    logic [1:0] age;
    logic live;
    logic rd;
    // Design logic trails the pin by two edges after release
    assign live = age == 2'd3;
    assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            age <= 2'd0;
        end else if (!live) begin
            age <= age + 2'd1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_reset_clears:
    assert property ($rose(arst_n) |-> request_level_outputs == LVL_NONE
        ##1 request_level_outputs == LVL_NONE)
        else $error("request level not zero after reset");
    a_wdog_first:
    assert property (live && evt.wdog_timeout && !irq_ack ##1 !irq_ack
        |-> ##1 request_level_outputs == LVL_WDOG)
        else $error("watchdog level not presented");
    a_ack_clears:
    assert property (live && irq_ack && ack_trap_type == 8'h1F
        && !evt.wdog_timeout |-> ##2 (request_level_outputs != LVL_WDOG
        || $past(evt.wdog_timeout)))
        else $error("acknowledged level still presented");
    a_halt_req:
    assert property (live |-> hw_err_halt_req ==
        $past(|(hw_err_flags & ~hw_err_masked)))
        else $error("halt request does not follow unmasked errors");
    a_pulse_cause:
    assert property (live && ext_ack_pulse |-> $past(irq_ack)
        && $past(ack_trap_type) inside {8'h12, 8'h13, 8'h1A, 8'h1B, 8'h1E})
        else $error("acknowledge pulse without external acknowledge");
    a_pulse_single:
    assert property (ext_ack_pulse |=> !ext_ack_pulse)
        else $error("acknowledge pulse longer than one cycle");
    a_mask_top:
    assert property (live && rd && apb_req.paddr == OFF_MASK
        |=> !apb_rsp.prdata[15] && !apb_rsp.prdata[0])
        else $error("mask bit of top level reads as set");
    a_status_view:
    assert property (live && rd && apb_req.paddr == OFF_STATUS |=>
        apb_rsp.prdata[4:0] ==
        {$past(hw_err_halt_req), $past(request_level_outputs)})
        else $error("status register disagrees with outputs");
endmodule
bind interrupt_trap_controller intc_checker #(
    .HW_ERR_BITS(HW_ERR_BITS)
) intc_checker_i (.clk, .arst_n, .apb_req, .apb_rsp, .ext_irq, .evt,
    .hw_err_flags, .hw_err_masked, .hw_err_halt_req,
    .request_level_outputs, .irq_ack, .ack_trap_type, .ext_ack_pulse);
`default_nettype wire

//--- core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model
    import intc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bench control
    input wire logic enable,
    input wire logic [2:0] delay,
    // Interrupt side
    input wire logic [LVL_W-1:0] level,
    output logic irq_ack,
    output logic [7:0] ack_trap_type
);
    logic [3:0] wait_cnt;
    logic fire_now;
    // Floor of three: the level only drops two edges after an ack
    assign fire_now = enable && level != LVL_NONE && !irq_ack
        && wait_cnt == 4'(delay) + 4'd3;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt <= 4'h0;
            irq_ack <= 1'b0;
            ack_trap_type <= 8'h00;
        end else begin
            irq_ack <= fire_now;
            wait_cnt <= (!enable || level == LVL_NONE || fire_now) ?
                4'h0 : wait_cnt + 4'h1;
            // Outside an ack the trap type is scrambled, not held
            ack_trap_type <= fire_now ? {TT_BASE_HI, level} :
                ~ack_trap_type;
        end
    end
endmodule
`default_nettype wire

//--- interrupt_trap_controller_test.sv
`timescale 1ns/1ns
`default_nettype none
module interrupt_trap_controller_test
    import intc_pkg::*;
;
    localparam int EV_LVL[9] = '{4, 5, 6, 7, 8, 9, 12, 13, 15};
    localparam int EXT_LVL[5] = '{2, 3, 10, 11, 14};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic [NUM_EXT-1:0] ext_irq = 5'h1f;
    evt_t evt = '0;
    logic [7:0] flags = 8'h00;
    logic [7:0] hmask = 8'h00;
    logic en = 1'b0;
    logic [2:0] dly = 3'h0;
    logic halt, ack, pulse, rerr;
    logic [LVL_W-1:0] lvl;
    logic [7:0] tt;
    logic [8:0] ev;
    logic [31:0] rdata;
    integer seed = 32'hbd97_7e5b;
    int n_errors = 0, n_compared = 0, cycles = 0, acks = 0;
    always #10 clk = ~clk;
    interrupt_trap_controller interrupt_trap_controller_i (
        .clk, .arst_n, .apb_req(req), .apb_rsp(rsp), .ext_irq, .evt,
        .hw_err_flags(flags), .hw_err_masked(hmask), .hw_err_halt_req(halt),
        .request_level_outputs(lvl), .irq_ack(ack), .ack_trap_type(tt),
        .ext_ack_pulse(pulse));
    core_model core_model_i (.clk, .arst_n, .enable(en), .delay(dly),
        .level(lvl), .irq_ack(ack), .ack_trap_type(tt));
    function automatic logic [31:0] pend_of(input logic [8:0] e);
        pend_of = '0;
        for (int i = 0; i < 9; i++)
            if (e[i]) pend_of[EV_LVL[i]] = 1'b1;
    endfunction
    function automatic logic [31:0] top_of(input logic [8:0] e);
        top_of = '0;
        for (int i = 0; i < 9; i++)
            if (e[i]) top_of = EV_LVL[i];
    endfunction
    task automatic close_out();
        $display("mismatches %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata, exp);
    endtask
    task automatic fire(input logic [8:0] e, input int exp);
        evt <= evt_t'(e);
        tick(1);
        evt <= '0;
        tick(3);
        check(32'(lvl), exp);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pulse === 1'b1)
            acks <= acks + 1;
        if (cycles == 8000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        tick(3);
        check(32'(lvl), 0);
        rd(OFF_MASK, 32'h0000_7ffe);
        apb(1'b1, OFF_MASK, 32'hffff_ffff);
        rd(OFF_MASK, 32'h0000_7ffe);
        apb(1'b1, 8'h20, 32'h0000_0001);
        check(32'(rerr), 1);
        apb(1'b1, OFF_MASK, 32'h0000_0000);
        for (int i = 0; i < 30; i++) begin
            ev = (i < 9) ? 9'(1 << i) : 9'($random(seed));
            fire(ev, top_of(ev));
            rd(OFF_PENDING, pend_of(ev));
            apb(1'b1, OFF_CLEAR, 32'h0000_fffe);
            tick(1);
            check(32'(lvl), 0);
        end
        fire(9'h001, 4);
        fire(9'h080, 13);
        apb(1'b1, OFF_MASK, 32'h0000_2000);
        tick(1);
        check(32'(lvl), 4);
        rd(OFF_PENDING, 32'h0000_2010);
        apb(1'b1, OFF_MASK, 32'h0000_fffe);
        fire(9'h100, 15);
        en <= 1'b1;
        tick(12);
        en <= 1'b0;
        check(32'(lvl), 0);
        arst_n <= 1'b0;
        tick(2);
        arst_n <= 1'b1;
        tick(3);
        rd(OFF_PENDING, 32'h0000_0000);
        apb(1'b1, OFF_MASK, 32'h0000_0000);
        for (int k = 0; k < 5; k++) begin
            ext_irq[k] <= 1'b0;
            tick(1);
            ext_irq[k] <= 1'b1;
            tick(6);
            check(32'(lvl), 0);
            ext_irq[k] <= 1'b0;
            tick(7);
            check(32'(lvl), EXT_LVL[k]);
            ext_irq[k] <= 1'b1;
            tick(6);
            check(32'(lvl), 0);
        end
        apb(1'b1, OFF_SHAPE, 32'h0000_07ff);
        ext_irq <= 5'h00;
        tick(6);
        apb(1'b1, OFF_CLEAR, 32'h0000_fffe);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, OFF_SHAPE, 32'h0000_07ff | (k << 11));
            acks = 0;
            ext_irq[k] <= 1'b1;
            tick(3);
            ext_irq[k] <= 1'b0;
            tick(6);
            check(32'(lvl), EXT_LVL[k]);
            dly <= 3'($random(seed));
            en <= 1'b1;
            tick(20);
            en <= 1'b0;
            check(32'(lvl), 0);
            check(acks, 1);
        end
        ext_irq <= 5'h1f;
        apb(1'b1, OFF_SHAPE, 32'h0000_03e0);
        tick(6);
        apb(1'b1, OFF_CLEAR, 32'h0000_fffe);
        ext_irq[0] <= 1'b0;
        tick(3);
        ext_irq[0] <= 1'b1;
        tick(6);
        check(32'(lvl), 2);
        apb(1'b1, OFF_CLEAR, 32'h0000_0004);
        tick(1);
        check(32'(lvl), 0);
        flags <= 8'h01;
        hmask <= 8'h01;
        tick(4);
        check(32'(lvl), 1);
        flags <= 8'h02;
        tick(3);
        apb(1'b1, OFF_CLEAR, 32'h0000_0002);
        tick(1);
        rd(OFF_STATUS, 32'h0000_0010);
        close_out();
    end
endmodule
`default_nettype wire
